// >>> design/port_mode_pkg.sv
// Purpose: Constants shared by the serial port mode selector.
// Assumes: 125 MHz controller clock, received characters arrive as byte strobes.
// Notes: Contract
package port_mode_pkg;
    localparam logic [7:0] DEL_CHAR = 8'h7F;
    localparam logic signed [15:0] MODE_CONST_ACTIVE = 16'sh0001;
    localparam logic signed [15:0] MODE_CONST_PASSIVE = 16'sh0002;
    localparam logic [15:0] MODE_CONST_RESET = 16'h0000;
    localparam logic [1:0] RUN_SYNC_RESET = 2'h0;
    localparam logic [1:0] SENSE_SYNC_RESET = 2'h3;
    localparam logic ACTIVE_RESET = 1'b1;
    localparam logic REINIT_RESET = 1'b1;
    localparam logic [3:0] ACT_DATA_BITS = 4'h8;
    localparam logic [1:0] ACT_STOP_BITS = 2'h1;
    localparam logic [1:0] ACT_PARITY = 2'h0;
    localparam logic [15:0] ACT_BAUD = 16'h2580;
    localparam logic ACT_RTS_CTS = 1'b1;
    localparam logic [1:0] SYNC_STAGES = 2'h2;
endpackage

// >>> design/port_param_if.sv
// Purpose: Carries the serial line parameter set between modules.
// Assumes: Single clock domain.
// Notes: The source drives all fields; the sink only reads.
interface port_param_if;
    logic [3:0] data_bits;
    logic [1:0] stop_bits;
    logic [1:0] parity;
    logic [15:0] baud;
    logic rts_cts;
    modport src (output data_bits, stop_bits, parity, baud, rts_cts);
    modport snk (input data_bits, stop_bits, parity, baud, rts_cts);
endinterface

// >>> design/port_param_sel.sv
// Purpose: Chooses the fixed active set or the user set for the port.
// Assumes: User set comes from the passive-mode setup logic.
// Notes: Purely combinational; registered by the top module.
module port_param_sel
    import port_mode_pkg::*;
(
    input wire logic active_in,
    input wire logic [3:0] usr_data_bits_in,
    input wire logic [1:0] usr_stop_bits_in,
    input wire logic [1:0] usr_parity_in,
    input wire logic [15:0] usr_baud_in,
    input wire logic usr_rts_cts_in,
    port_param_if.src prm
);
    always_comb begin
        if (active_in) begin
            // The user set is ignored here so test access can never be locked out.
            prm.data_bits = ACT_DATA_BITS;
            prm.stop_bits = ACT_STOP_BITS;
            prm.parity = ACT_PARITY;
            prm.baud = ACT_BAUD;
            prm.rts_cts = ACT_RTS_CTS;
        end else begin
            prm.data_bits = usr_data_bits_in;
            prm.stop_bits = usr_stop_bits_in;
            prm.parity = usr_parity_in;
            prm.baud = usr_baud_in;
            prm.rts_cts = usr_rts_cts_in;
        end
    end
endmodule

// >>> design/serial_port_mode_select.sv
// Purpose: Decides active or passive mode of serial port one and steers its traffic.
// Assumes: Switch and cable sense are pins; other inputs are on MCLK_IN.
// Notes: Cable sense low means shorted to zero volts.
module serial_port_mode_select
    import port_mode_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    // Pins
    input wire logic RUN_SWITCH_IN,
    input wire logic CABLE_SENSE_IN,
    // Mode constant write from the program side
    input wire logic CONST_WR_IN,
    input wire logic [15:0] CONST_DATA_IN,
    // Received characters
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_DATA_IN,
    // Passive-mode user parameter set
    input wire logic [3:0] USR_DATA_BITS_IN,
    input wire logic [1:0] USR_STOP_BITS_IN,
    input wire logic [1:0] USR_PARITY_IN,
    input wire logic [15:0] USR_BAUD_IN,
    input wire logic USR_RTS_CTS_IN,
    // Mode and routing
    output logic ACTIVE_OUT,
    output logic [15:0] CONST_IMAGE_OUT,
    output logic TEST_RX_VALID_OUT,
    output logic USER_RX_VALID_OUT,
    output logic [7:0] RX_DATA_OUT,
    output logic REINIT_OUT,
    // Line parameters
    output logic [3:0] DATA_BITS_OUT,
    output logic [1:0] STOP_BITS_OUT,
    output logic [1:0] PARITY_OUT,
    output logic [15:0] BAUD_OUT,
    output logic RTS_CTS_OUT
);
    logic [1:0] run_sync_r;
    logic [1:0] sense_sync_r;
    logic [15:0] const_r;
    logic [15:0] const_nxt;
    logic del_seen_r;
    logic active_r;
    logic active_nxt;
    logic double_del;
    logic signed [15:0] kc;

    port_param_if prm ();

    // The delete test is shared by the command detector and the user path filter.
    function automatic logic is_del(input logic [7:0] ch);
        return ch == DEL_CHAR;
    endfunction

    // A constant outside 1 and 2 falls back to the cable, so a bad value never locks out test access.
    function automatic logic decide_active(
        input logic run_ok,
        input logic signed [15:0] cval,
        input logic sense_open
    );
        logic res;
        res = sense_open;
        if (!run_ok) begin
            res = 1'b1;
        end else if (cval == MODE_CONST_ACTIVE) begin
            res = 1'b1;
        end else if (cval == MODE_CONST_PASSIVE) begin
            res = 1'b0;
        end
        return res;
    endfunction

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            run_sync_r <= RUN_SYNC_RESET;
        end else begin
            run_sync_r <= {run_sync_r[0], RUN_SWITCH_IN};
        end
    end

    // Starting the sense chain at open keeps test access until the pin has been seen.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sense_sync_r <= SENSE_SYNC_RESET;
        end else begin
            sense_sync_r <= {sense_sync_r[0], CABLE_SENSE_IN};
        end
    end

    // A DEL pair is only a command in passive mode; in active mode DEL is ordinary input.
    assign double_del = !active_r && RX_VALID_IN && is_del(RX_DATA_IN) && del_seen_r;

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            del_seen_r <= 1'b0;
        end else if (active_r) begin
            del_seen_r <= 1'b0;
        end else if (RX_VALID_IN) begin
            del_seen_r <= is_del(RX_DATA_IN) && !del_seen_r;
        end
    end

    // The command takes priority over a program write in the same cycle.
    always_comb begin
        const_nxt = const_r;
        if (double_del) begin
            const_nxt = 16'(MODE_CONST_ACTIVE);
        end else if (CONST_WR_IN) begin
            const_nxt = CONST_DATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            const_r <= MODE_CONST_RESET;
        end else begin
            const_r <= const_nxt;
        end
    end

    // The command is folded in here so the mode flips in the same cycle as the image.
    always_comb begin
        kc = const_r;
        if (double_del) begin
            kc = MODE_CONST_ACTIVE;
        end
        // Open pin reads high, a short to zero volts reads low.
        active_nxt = decide_active(run_sync_r[1], kc, sense_sync_r[1]);
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            active_r <= ACTIVE_RESET;
        end else begin
            active_r <= active_nxt;
        end
    end

    // The pulse stands during reset so the port starts from a known parameter set.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REINIT_OUT <= REINIT_RESET;
        end else begin
            REINIT_OUT <= active_nxt != active_r;
        end
    end

    // Data follows the line every cycle; only the two valids say who may take it.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RX_DATA_OUT <= 8'h00;
        end else begin
            RX_DATA_OUT <= RX_DATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            TEST_RX_VALID_OUT <= 1'b0;
        end else begin
            TEST_RX_VALID_OUT <= RX_VALID_IN && active_r;
        end
    end

    // A lone DEL is dropped as well, since it cannot be told from the first of a pair in time.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            USER_RX_VALID_OUT <= 1'b0;
        end else begin
            USER_RX_VALID_OUT <= RX_VALID_IN && !active_r && !is_del(RX_DATA_IN);
        end
    end

    port_param_sel u_sel (
        .active_in(active_nxt),
        .usr_data_bits_in(USR_DATA_BITS_IN),
        .usr_stop_bits_in(USR_STOP_BITS_IN),
        .usr_parity_in(USR_PARITY_IN),
        .usr_baud_in(USR_BAUD_IN),
        .usr_rts_cts_in(USR_RTS_CTS_IN),
        .prm(prm.src)
    );

    // Parameters load with the mode so the re-init pulse sees the new set.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            DATA_BITS_OUT <= ACT_DATA_BITS;
            STOP_BITS_OUT <= ACT_STOP_BITS;
            PARITY_OUT <= ACT_PARITY;
        end else begin
            DATA_BITS_OUT <= prm.data_bits;
            STOP_BITS_OUT <= prm.stop_bits;
            PARITY_OUT <= prm.parity;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            BAUD_OUT <= ACT_BAUD;
            RTS_CTS_OUT <= ACT_RTS_CTS;
        end else begin
            BAUD_OUT <= prm.baud;
            RTS_CTS_OUT <= prm.rts_cts;
        end
    end

    // The mode output has its own flop so it leaves the block straight from a register.
    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ACTIVE_OUT <= ACTIVE_RESET;
        end else begin
            ACTIVE_OUT <= active_nxt;
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            CONST_IMAGE_OUT <= MODE_CONST_RESET;
        end else begin
            CONST_IMAGE_OUT <= const_nxt;
        end
    end
endmodule

// >>> tb/spms_chk.sv
// Purpose: Port-level checks on the serial port mode selector.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Bound to the top module from the testbench file.
module spms_chk
    import port_mode_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic RUN_SWITCH_IN,
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic ACTIVE_OUT,
    input wire logic [15:0] CONST_IMAGE_OUT,
    input wire logic TEST_RX_VALID_OUT,
    input wire logic USER_RX_VALID_OUT,
    input wire logic [7:0] RX_DATA_OUT,
    input wire logic REINIT_OUT,
    input wire logic [3:0] DATA_BITS_OUT,
    input wire logic [1:0] STOP_BITS_OUT,
    input wire logic [1:0] PARITY_OUT,
    input wire logic [15:0] BAUD_OUT,
    input wire logic RTS_CTS_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    a_reinit_on_change: assert property ($changed(ACTIVE_OUT) |-> REINIT_OUT)
        else $error("no port re-init on mode change");
    a_reinit_only_change: assert property (REINIT_OUT && $past(ARST_N_IN) |-> $changed(ACTIVE_OUT))
        else $error("port re-init without mode change");
    a_active_fixed_set: assert property (ACTIVE_OUT |-> {DATA_BITS_OUT, STOP_BITS_OUT, PARITY_OUT,
        BAUD_OUT, RTS_CTS_OUT} == {ACT_DATA_BITS, ACT_STOP_BITS, ACT_PARITY, ACT_BAUD, ACT_RTS_CTS})
        else $error("active line parameters wrong");
    a_test_path: assert property (RX_VALID_IN && ACTIVE_OUT ##1 ACTIVE_OUT
        |-> TEST_RX_VALID_OUT && !USER_RX_VALID_OUT)
        else $error("active char not sent to test path");
    a_user_path: assert property (RX_VALID_IN && !ACTIVE_OUT && RX_DATA_IN != DEL_CHAR ##1 !ACTIVE_OUT
        |-> USER_RX_VALID_OUT && !TEST_RX_VALID_OUT && RX_DATA_OUT == $past(RX_DATA_IN))
        else $error("passive char not sent to user path");
    a_del_hidden: assert property (RX_VALID_IN && RX_DATA_IN == DEL_CHAR |=> !USER_RX_VALID_OUT)
        else $error("delete char reached user path");
    a_stop_active: assert property (!RUN_SWITCH_IN [*4] |-> ACTIVE_OUT)
        else $error("stop switch did not force active mode");
    a_del_pair: assert property (RX_VALID_IN && RX_DATA_IN == DEL_CHAR && !ACTIVE_OUT ##1 !RX_VALID_IN
        ##1 RX_VALID_IN && RX_DATA_IN == DEL_CHAR |=> ACTIVE_OUT && CONST_IMAGE_OUT == 16'h0001)
        else $error("delete pair did not switch to active");
    a_const_passive: assert property (RUN_SWITCH_IN [*4] ##0 (CONST_IMAGE_OUT == 16'h0002) [*2]
        |-> !ACTIVE_OUT)
        else $error("constant two did not give passive");
endmodule

// >>> tb/far_end_model.sv
// Purpose: Cable and attached device on the far side of the serial port.
// Assumes: Characters arrive already deframed, one strobe each.
// Notes: Released data shows the inverse of the last character.
module far_end_model (
    input wire logic clk_in,
    output logic sense_out,
    output logic valid_out,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sense_out = 1'b1;
        valid_out = 1'b0;
        data_out = 8'h00;
    end
    // The passive cable shorts sense to zero volts; open reads high.
    task automatic plug(input logic passive);
        sense_out = !passive;
    endtask
    // A switch request is two delete characters in a row.
    task automatic send(input logic [7:0] ch);
        @(posedge clk_in);
        #1 valid_out = 1'b1;
        data_out = ch;
        @(posedge clk_in);
        #1 valid_out = 1'b0;
        data_out = ~ch;
    endtask
endmodule

// >>> tb/serial_port_mode_select_tb.sv
// Purpose: Self-checking bench for the serial port mode selector.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: The user parameter set is changed once while the port is passive.
module serial_port_mode_select_tb
    import port_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b1;
    logic wr = 1'b0;
    logic [15:0] cdata = 16'h0000;
    logic sense, rxv, act, tv, uv, reinit, rts;
    logic [7:0] rxd, rx_q;
    logic [15:0] img, baud;
    logic [3:0] db;
    logic [1:0] sb, par;
    logic [3:0] udb = 4'h7;
    logic [1:0] usb = 2'h2;
    logic [1:0] upar = 2'h1;
    logic [15:0] ubaud = 16'h1234;
    logic urc = 1'b0;
    int err_count = 0;
    int cmp_count = 0;
    far_end_model u_far (.clk_in(clk), .sense_out(sense), .valid_out(rxv), .data_out(rxd));
    serial_port_mode_select u_dut (.MCLK_IN(clk), .ARST_N_IN(rst_n), .RUN_SWITCH_IN(run),
        .CABLE_SENSE_IN(sense), .CONST_WR_IN(wr), .CONST_DATA_IN(cdata), .RX_VALID_IN(rxv),
        .RX_DATA_IN(rxd), .USR_DATA_BITS_IN(udb), .USR_STOP_BITS_IN(usb), .USR_PARITY_IN(upar),
        .USR_BAUD_IN(ubaud), .USR_RTS_CTS_IN(urc), .ACTIVE_OUT(act), .CONST_IMAGE_OUT(img),
        .TEST_RX_VALID_OUT(tv), .USER_RX_VALID_OUT(uv), .RX_DATA_OUT(rx_q), .REINIT_OUT(reinit),
        .DATA_BITS_OUT(db), .STOP_BITS_OUT(sb), .PARITY_OUT(par), .BAUD_OUT(baud), .RTS_CTS_OUT(rts));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic set_mode(input logic r, input logic p, input logic [15:0] c);
        run = r;
        u_far.plug(p);
        cdata = c;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(5);
    endtask
    // Rows: stop, open, shorted, minus one, three, one, two.
    task automatic t_modes;
        logic [15:0] cv [7];
        logic [6:0] run_rows;
        logic [6:0] short_rows;
        logic [6:0] act_rows;
        cv = '{16'h0002, 16'h0000, 16'h0000, 16'hFFFF, 16'h0003, 16'h0001, 16'h0002};
        run_rows = 7'h7E;
        short_rows = 7'h2D;
        act_rows = 7'h33;
        for (int i = 0; i < 7; i++) begin
            set_mode(run_rows[i], short_rows[i], cv[i]);
            chk(act, act_rows[i]);
            chk(img, cv[i]);
        end
    endtask
    task automatic t_del;
        set_mode(1'b1, 1'b0, 16'h0002);
        chk({db, sb, par, rts}, {4'h7, 2'h2, 2'h1, 1'b0});
        chk(baud, 16'h1234);
        udb = 4'h6;
        ubaud = 16'h04B0;
        urc = 1'b1;
        tick(2);
        chk({db, rts}, {4'h6, 1'b1});
        chk(baud, 16'h04B0);
        u_far.send(8'h55);
        chk({tv, uv}, 2'h1);
        chk(rx_q, 8'h55);
        u_far.send(DEL_CHAR);
        chk(uv, 1'b0);
        u_far.send(8'h41);
        u_far.send(DEL_CHAR);
        tick(1);
        chk(act, 1'b0);
        u_far.send(DEL_CHAR);
        chk(act, 1'b1);
        chk(reinit, 1'b1);
        chk(img, 16'h0001);
        chk(baud, ACT_BAUD);
        chk(db, ACT_DATA_BITS);
        u_far.send(8'h33);
        chk(rx_q, 8'h33);
        chk({tv, uv, reinit}, 3'h4);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(2);
        t_modes();
        t_del();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
bind serial_port_mode_select spms_chk u_chk (.*);
